/* File: verilog/cco_config.v */
// Card configuration logic: host mode select, option register, decode mode.
// Assumes host attribute strobes are synchronous single-cycle pulses.
`timescale 1ns/100ps
`include "cco_map.vh"

module cco_config #(
	parameter PULSE_CYC = `CCO_IRQ_PULSE_CYC
) (
	// Clock and reset
	input wire sys_clk_in,
	input wire rst_n_in,
	input wire host_hard_reset_in,
	// Environment sense and processor override
	input wire true_ide_sense_in,
	input wire mode_override_en_in,
	input wire mode_override_val_in,
	// Attribute memory access
	input wire attr_sel_in,
	input wire [10:0] attr_addr_in,
	input wire attr_wr_in,
	input wire attr_rd_in,
	input wire [7:0] attr_wdata_in,
	// Task file interrupt condition
	input wire irq_req_in,
	// Outputs
	output reg [7:0] attr_rdata_out,
	output reg attr_rvalid_out,
	output reg host_mode_out,
	output reg iface_reset_out,
	output reg iface_enable_out,
	output reg [1:0] decode_mode_out,
	output reg io_mode_out,
	output reg [7:0] option_out,
	output wire irq_n_out
);

	////////////////////////////////////////////////////////////////////////////
	// Power-up environment capture
	reg powered;
	reg sensed_mode;
	wire hit;
	wire configured;
	reg [7:0] configuration_option;

	// Strap is caught after reset release, never under reset
	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			powered <= 1'b0;
			sensed_mode <= `CCO_MODE_PCCARD;
		end else if (!powered) begin
			powered <= 1'b1;
			sensed_mode <= true_ide_sense_in;
		end
	end

	// Processor override wins over sensed mode
	always @(posedge sys_clk_in) begin
		if (!rst_n_in)
			host_mode_out <= `CCO_MODE_PCCARD;
		else if (mode_override_en_in)
			host_mode_out <= mode_override_val_in;
		else if (powered)
			host_mode_out <= sensed_mode;
	end

	////////////////////////////////////////////////////////////////////////////
	// Option register in attribute space
	assign hit = attr_sel_in & (attr_addr_in == `CCO_OPTION_ADDR);
	// Hard reset only counts once a mode is settled (configured)
	assign configured = powered;

	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			configuration_option <= `CCO_OPTION_RESET;
		end else if (host_hard_reset_in && configured) begin
			configuration_option <= `CCO_OPTION_RESET;
		end else if (hit && attr_wr_in) begin
			configuration_option <= attr_wdata_in;
		end else if (configuration_option[`CCO_SOFT_RESET_BIT]) begin
			// Soft reset clears other fields, bit itself stays until host writes zero or a hard reset clears it
			configuration_option[`CCO_SOFT_RESET_BIT-1:0] <= 7'h00;
		end
	end

	// Read path: unmapped attribute reads return zero
	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			attr_rdata_out <= 8'h00;
			attr_rvalid_out <= 1'b0;
		end else begin
			attr_rvalid_out <= attr_sel_in & attr_rd_in;
			if (hit && attr_rd_in)
				attr_rdata_out <= configuration_option;
			else
				attr_rdata_out <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Derived interface controls
	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			iface_reset_out <= 1'b1;
			iface_enable_out <= 1'b0;
			decode_mode_out <= `CCO_DEC_MEM_LINEAR;
			io_mode_out <= 1'b0;
			option_out <= `CCO_OPTION_RESET;
		end else begin
			iface_reset_out <= configuration_option[`CCO_SOFT_RESET_BIT] | host_hard_reset_in;
			// Zero index: attribute accesses only
			iface_enable_out <= |configuration_option[`CCO_INDEX_HI:`CCO_INDEX_LO];
			decode_mode_out <= configuration_option[1:0];
			io_mode_out <= (configuration_option[1:0] != `CCO_DEC_MEM_LINEAR);
			option_out <= configuration_option;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt line; request masked while interface is held in reset
	cco_irq_gen #(
		.PULSE_CYC(PULSE_CYC)
	) u_irq (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.level_mode_in(configuration_option[`CCO_LEVEL_SEL_BIT]),
		.irq_req_in(irq_req_in & ~iface_reset_out),
		.irq_n_out(irq_n_out)
	);

endmodule // cco_config

/* File: verilog/cco_map.vh */
// Constants for the card configuration option register block.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef CCO_MAP_VH
`define CCO_MAP_VH

// Attribute memory map
`define CCO_ADDR_W 11
`define CCO_OPTION_ADDR 11'h200

// Option register fields
`define CCO_SOFT_RESET_BIT 7
`define CCO_LEVEL_SEL_BIT 6
`define CCO_INDEX_HI 5
`define CCO_INDEX_LO 0
`define CCO_OPTION_RESET 8'h00

// Decode modes from index bits 1:0
`define CCO_DEC_MEM_LINEAR 2'h0
`define CCO_DEC_IO_LINEAR 2'h1
`define CCO_DEC_IO_PRIMARY 2'h2
`define CCO_DEC_IO_SECONDARY 2'h3

// Host mode encoding
`define CCO_MODE_PCCARD 1'b0
`define CCO_MODE_TRUE_IDE 1'b1

// Interrupt pulse timing
`define CCO_CLK_PERIOD_PS 10000
`define CCO_IRQ_PULSE_PS 500000
`define CCO_IRQ_PULSE_CYC ((`CCO_IRQ_PULSE_PS + `CCO_CLK_PERIOD_PS - 1) / `CCO_CLK_PERIOD_PS)

`endif

/* File: verilog/cco_irq_gen.v */
// Interrupt line generator: level or pulsed, active low.
// Assumes request is a level from the task file logic, synchronous to the clock.
`timescale 1ns/100ps
`include "cco_map.vh"

module cco_irq_gen #(
	parameter PULSE_CYC = `CCO_IRQ_PULSE_CYC
) (
	// Clock and reset
	input wire sys_clk_in,
	input wire rst_n_in,
	// Control
	input wire level_mode_in,
	input wire irq_req_in,
	// Interrupt line
	output reg irq_n_out
);

	////////////////////////////////////////////////////////////////////////////
	reg req_q;
	reg [15:0] pulse_cnt;
	wire req_rise;

	assign req_rise = irq_req_in & ~req_q;

	// Pulse counter runs the full width even if request drops early
	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			req_q <= 1'b0;
			pulse_cnt <= 16'h0000;
			irq_n_out <= 1'b1;
		end else begin
			req_q <= irq_req_in;
			if (level_mode_in) begin
				pulse_cnt <= 16'h0000;
				irq_n_out <= ~irq_req_in;
			end else if (req_rise) begin
				pulse_cnt <= PULSE_CYC[15:0] - 16'h0001;
				irq_n_out <= 1'b0;
			end else if (pulse_cnt != 16'h0000) begin
				pulse_cnt <= pulse_cnt - 16'h0001;
				irq_n_out <= 1'b0;
			end else begin
				irq_n_out <= 1'b1;
			end
		end
	end

endmodule // cco_irq_gen

/* File: tb/cco_config_props.sv */
// Port checker for the configuration option block.
// Assumes the bench sets PULSE_CYC to 4.
`timescale 1ns/100ps
module cco_props (
	input wire sys_clk_in, rst_n_in, host_hard_reset_in, attr_sel_in, attr_wr_in, attr_rd_in,
	input wire [10:0] attr_addr_in,
	input wire [7:0] attr_wdata_in, attr_rdata_out, option_out,
	input wire irq_req_in, attr_rvalid_out, iface_reset_out, iface_enable_out, irq_n_out,
	input wire [1:0] decode_mode_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Decode of the option register address
	wire hit = attr_sel_in && attr_addr_in == 11'h200;
	sequence s_low4;
		!irq_n_out [*4];
	endsequence
	a_read_answer: assert property (attr_rd_in && hit |=> attr_rvalid_out) else $error("no read answer");
	a_unmapped_zero: assert property (attr_rd_in && attr_sel_in && !hit |=> attr_rdata_out == 8'h00) else $error("unmapped read not zero");
	a_write_lands: assert property (attr_wr_in && hit && !host_hard_reset_in |-> ##2 option_out == $past(attr_wdata_in, 2)) else $error("write lost");
	a_enable_index: assert property (iface_enable_out == (option_out[5:0] != 6'h00)) else $error("enable wrong");
	a_decode_index: assert property (decode_mode_out == option_out[1:0]) else $error("decode wrong");
	a_soft_hold: assert property (option_out[7] |-> iface_reset_out) else $error("soft reset not held");
	a_pulse_width: assert property ($fell(irq_n_out) && !option_out[6] |-> s_low4) else $error("pulse short");
	a_level_follow: assert property (option_out[6] && $past(option_out[6]) && !$past(option_out[7]) && !$past(host_hard_reset_in, 2) |-> irq_n_out == !$past(irq_req_in)) else $error("level irq wrong");
	a_hard_clear: assert property (host_hard_reset_in |-> ##2 option_out == 8'h00) else $error("hard reset missed");
endmodule // cco_props
bind cco_config cco_props cco_props_u (.*);

/* File: tb/cco_host_model.sv */
// Host socket model: attribute space cycles on the falling edge.
// Assumes the bench calls its tasks in sequence.
`timescale 1ns/100ps
module cco_host_model (
	input wire sys_clk_in,
	input wire [7:0] attr_rdata_in,
	output reg sel_out, wr_out, rd_out,
	output reg [10:0] addr_out,
	output reg [7:0] wdata_out
);
	initial {sel_out, wr_out, rd_out, addr_out, wdata_out} = 0;
	// Index written before any task-file access; lines scrambled once released
	task wr(input [10:0] a, input [7:0] d);
		@(negedge sys_clk_in) {sel_out, wr_out, addr_out, wdata_out} = {2'b11, a, d};
		@(negedge sys_clk_in) {sel_out, wr_out, addr_out, wdata_out} = {2'b00, ~a, ~d};
	endtask
	task rd(input [10:0] a, output [7:0] d);
		@(negedge sys_clk_in) {sel_out, rd_out, addr_out} = {2'b11, a};
		@(negedge sys_clk_in) {sel_out, rd_out, addr_out} = {2'b00, ~a};
		d = attr_rdata_in;
	endtask
endmodule // cco_host_model

/* File: tb/card_config_option_register_tb.sv */
// Bench for the configuration option block.
// Assumes one clock; host cycles come from the host model.
`timescale 1ns/100ps
module card_config_option_register_tb;
	reg sys_clk_in = 0, rst_n_in = 0, hrst = 0, sense = 1, ov_en = 0, ov_val = 0, irq = 0;
	wire sel, wr, rd, rv, hm, ir, en, io, irq_n;
	wire [10:0] a;
	wire [7:0] wd, rdat, opt;
	wire [1:0] dm;
	reg [7:0] d;
	integer bad_count = 0, n_tests = 0, i;
	always #5 sys_clk_in = ~sys_clk_in;
	cco_host_model h_u (.sys_clk_in(sys_clk_in), .attr_rdata_in(rdat), .sel_out(sel),
		.wr_out(wr), .rd_out(rd), .addr_out(a), .wdata_out(wd));
	cco_config #(.PULSE_CYC(4)) dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.host_hard_reset_in(hrst), .true_ide_sense_in(sense), .mode_override_en_in(ov_en),
		.mode_override_val_in(ov_val), .attr_sel_in(sel), .attr_addr_in(a), .attr_wr_in(wr),
		.attr_rd_in(rd), .attr_wdata_in(wd), .irq_req_in(irq), .attr_rdata_out(rdat),
		.attr_rvalid_out(rv), .host_mode_out(hm), .iface_reset_out(ir), .iface_enable_out(en),
		.decode_mode_out(dm), .io_mode_out(io), .option_out(opt), .irq_n_out(irq_n));
	////////////////////////////////////////////////////////////////
	task chk(input [7:0] g, input [7:0] e);
		n_tests = n_tests + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("wrong value at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task wait_n(input integer n);
		repeat (n) @(negedge sys_clk_in);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#100000 bad_count = bad_count + 1;
		complete_run;
	end
	initial begin
		wait_n(16);
		rst_n_in = 1;
		wait_n(3);
		chk(hm, 8'h01);
		h_u.rd(11'h200, d); chk(d, 8'h00);
		ov_en = 1; wait_n(3); chk(hm, 8'h00);
		for (i = 0; i < 4; i = i + 1) begin
			h_u.wr(11'h200, 8'h04 | i); h_u.rd(11'h200, d); chk(d, 8'h04 | i);
			chk({en, io, dm}, {2'b10 | (i != 0), i[1:0]});
		end
		h_u.rd(11'h202, d); chk(d, 8'h00);
		h_u.wr(11'h200, 8'h85); wait_n(2); h_u.rd(11'h200, d); chk(d, 8'h80);
		chk(ir, 8'h01);
		h_u.wr(11'h200, 8'h01); wait_n(2); chk(ir, 8'h00);
		irq = 1; wait_n(2); chk(irq_n, 8'h00); wait_n(6); chk(irq_n, 8'h01);
		irq = 0; h_u.wr(11'h200, 8'h41); irq = 1; wait_n(3); chk(irq_n, 8'h00);
		irq = 0; wait_n(2); chk(irq_n, 8'h01);
		hrst = 1; wait_n(1); hrst = 0; h_u.rd(11'h200, d); chk(d, 8'h00);
		// Power-on reset in mid-run must clear a freshly written register
		h_u.wr(11'h200, 8'h45); rst_n_in = 0; wait_n(2); rst_n_in = 1; wait_n(3);
		h_u.rd(11'h200, d); chk(d, 8'h00);
		chk(en, 8'h00);
		complete_run;
	end
endmodule // card_config_option_register_tb
